// [hdl/acc_top.sv]
`timescale 1ns/1ps
module acc_top
   import acc_pkg::*;
#(
   parameter int VW = ACC_VW
) (
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   input  wire logic [ACC_AW-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [31:0]            reg_rdata,
   output logic                   irq,
   input  wire logic [VW-1:0]     cmp0_negative_input,
   input  wire logic [VW-1:0]     cmp0_positive_input,
   input  wire logic [VW-1:0]     cmp1_negative_input,
   input  wire logic [VW-1:0]     cmp2_negative_input,
   input  wire logic [VW-1:0]     cmp1_shared_pin_in,
   input  wire logic [VW-1:0]     cmp2_shared_pin_in,
   output logic                   cmp0_output_pin,
   output logic                   cmp1_shared_pin_out,
   output logic                   cmp1_shared_pin_oe_n,
   output logic                   cmp2_shared_pin_out,
   output logic                   cmp2_shared_pin_oe_n
);
   // register state
   logic [ACC_NCH-1:0] ris_q, ris_d;
   logic [ACC_NCH-1:0] inten_q, inten_d;
   logic [9:0]         ref_q, ref_d;
   logic [11:0]        ctl_q [ACC_NCH];
   logic [11:0]        ctl_d [ACC_NCH];
   logic [31:0]        rdata_q, rdata_d;
   logic               irq_q, irq_d;
   logic [ACC_NCH-1:0] pin_q, pin_d;
   logic [ACC_NCH-1:0] oe_n_q, oe_n_d;

   // channel wiring
   logic [VW-1:0]      neg_in [ACC_NCH];
   logic [VW-1:0]      pos_in [ACC_NCH];
   logic [VW-1:0]      pos_s  [ACC_NCH];
   logic [ACC_NCH-1:0] result;
   logic [ACC_NCH-1:0] event_hit;
   logic [4:0]         ref_num, ref_den;
   logic [ACC_NCH-1:0] clr;

   assign neg_in[0] = cmp0_negative_input;
   assign neg_in[1] = cmp1_negative_input;
   assign neg_in[2] = cmp2_negative_input;
   assign pos_in[0] = cmp0_positive_input;
   assign pos_in[1] = cmp1_shared_pin_in;
   assign pos_in[2] = cmp2_shared_pin_in;

   // byte offset of a channel register
   function automatic logic [7:0] ch_ofs(input logic [7:0] base,
                                          input int         ch);
      return base + 8'(ch) * ACC_CH_STEP;
   endfunction

   // reference ladder tap and ladder length
   always_comb begin
      ref_den = ref_q[ACC_REF_RNG] ? ACC_DEN_R1 : ACC_DEN_R0;
      if (!ref_q[ACC_REF_EN]) begin
         ref_num = 5'h00;
      end else if (ref_q[ACC_REF_RNG]) begin
         ref_num = {1'b0, ref_q[ACC_REF_TAP +: 4]};
      end else begin
         ref_num = {1'b0, ref_q[ACC_REF_TAP +: 4]} + ACC_TAP_OFS8;
      end
   end

   // three channels, sharing the reference and channel 0's positive input
   for (genvar i = 0; i < ACC_NCH; i++) begin : g_ch
      acc_chan #(
         .VW    (VW),
         .IS_C0 (i == 0)
      ) u_chan (
         .core_clk (core_clk),
         .reset_n  (reset_n),
         .neg_pin  (neg_in[i]),
         .pos_pin  (pos_in[i]),
         .c0_pos   (pos_s[0]),
         .src      (ctl_q[i][ACC_CTL_SRC +: 2]),
         .sense    (ctl_q[i][ACC_CTL_SNS +: 2]),
         .ref_num  (ref_num),
         .ref_den  (ref_den),
         .pos_sync (pos_s[i]),
         .result_q (result[i]),
         .event_q  (event_hit[i])
      );
   end

   // write-one-to-clear mask from a masked status write
   assign clr = (reg_wr && reg_addr == ACC_MIS_OFS) ?
                reg_wdata[ACC_NCH-1:0] : ACC_RST_FLAG;

   // next register values
   always_comb begin
      ris_d   = (ris_q & ~clr) | event_hit;
      inten_d = inten_q;
      ref_d   = ref_q;
      for (int i = 0; i < ACC_NCH; i++) begin
         ctl_d[i] = ctl_q[i];
      end
      if (reg_wr) begin
         if (reg_addr == ACC_INTEN_OFS) begin
            inten_d = reg_wdata[ACC_NCH-1:0];
         end
         if (reg_addr == ACC_REF_OFS) begin
            ref_d = {reg_wdata[ACC_REF_EN], reg_wdata[ACC_REF_RNG],
                     4'h0, reg_wdata[ACC_REF_TAP +: 4]};
         end
         for (int i = 0; i < ACC_NCH; i++) begin
            if (reg_addr == ch_ofs(ACC_CTL_OFS, i)) begin
               ctl_d[i] = reg_wdata[11:0] & ACC_CTL_MASK;
            end
         end
      end
   end

   // read data, unmapped offsets read zero
   always_comb begin
      rdata_d = ACC_RST_WORD;
      if (reg_rd) begin
         case (reg_addr)
            ACC_MIS_OFS:   rdata_d[ACC_NCH-1:0] = ris_q & inten_q;
            ACC_RIS_OFS:   rdata_d[ACC_NCH-1:0] = ris_q;
            ACC_INTEN_OFS: rdata_d[ACC_NCH-1:0] = inten_q;
            ACC_REF_OFS:   rdata_d[9:0] = ref_q;
            default: begin
               for (int i = 0; i < ACC_NCH; i++) begin
                  if (reg_addr == ch_ofs(ACC_STAT_OFS, i)) begin
                     rdata_d[ACC_STAT_RES] = result[i];
                  end
                  if (reg_addr == ch_ofs(ACC_CTL_OFS, i)) begin
                     rdata_d[11:0] = ctl_q[i];
                  end
               end
            end
         endcase
      end
   end

   // interrupt line and pin drivers
   always_comb begin
      irq_d = |(ris_q & inten_q);
      for (int i = 0; i < ACC_NCH; i++) begin
         pin_d[i]  = result[i] ^ ctl_q[i][ACC_CTL_INV];
         oe_n_d[i] = ~ctl_q[i][ACC_CTL_DRV];
      end
      oe_n_d[0] = 1'b0;
   end

   // register everything
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ris_q   <= ACC_RST_FLAG;
         inten_q <= ACC_RST_FLAG;
         ref_q   <= 10'h000;
         for (int i = 0; i < ACC_NCH; i++) begin
            ctl_q[i] <= 12'h000;
         end
         rdata_q <= ACC_RST_WORD;
         irq_q   <= 1'b0;
         pin_q   <= ACC_RST_FLAG;
         oe_n_q  <= 3'h7;
      end else begin
         ris_q   <= ris_d;
         inten_q <= inten_d;
         ref_q   <= ref_d;
         for (int i = 0; i < ACC_NCH; i++) begin
            ctl_q[i] <= ctl_d[i];
         end
         rdata_q <= rdata_d;
         irq_q   <= irq_d;
         pin_q   <= pin_d;
         oe_n_q  <= oe_n_d;
      end
   end

   assign reg_rdata            = rdata_q;
   assign irq                  = irq_q;
   assign cmp0_output_pin      = pin_q[0];
   assign cmp1_shared_pin_out  = pin_q[1];
   assign cmp2_shared_pin_out  = pin_q[2];
   assign cmp1_shared_pin_oe_n = oe_n_q[1];
   assign cmp2_shared_pin_oe_n = oe_n_q[2];

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_clear_write;
      reg_wr && reg_addr == ACC_MIS_OFS && reg_wdata[0];
   endsequence

   sequence s_no_event;
      !event_hit[0];
   endsequence

   AST_W1C_CLEARS: assert property (
      (s_clear_write and s_no_event) |=> !ris_q[0])
      else $error("write one did not clear flag 0");
   AST_SET_WINS: assert property (
      event_hit[1] |=> ris_q[1])
      else $error("event lost against a clear");
   AST_IRQ_MASKED: assert property (
      ##1 irq == |($past(ris_q) & $past(inten_q)))
      else $error("irq does not follow masked flags");
   AST_MIS_READ: assert property (
      (reg_rd && reg_addr == ACC_MIS_OFS)
         |=> reg_rdata[2:0] == ($past(ris_q) & $past(inten_q)))
      else $error("masked status read wrong");
   AST_STAT_READ: assert property (
      (reg_rd && reg_addr == ACC_STAT_OFS)
         |=> reg_rdata[ACC_STAT_RES] == $past(result[0]))
      else $error("status result readback wrong");
   AST_REF_GROUND: assert property (
      !ref_q[ACC_REF_EN] |-> ref_num == 5'h00)
      else $error("disabled reference not ground");
   AST_REF_RANGE0: assert property (
      (ref_q[ACC_REF_EN] && !ref_q[ACC_REF_RNG])
         |-> ref_num == ref_q[3:0] + 5'h08 && ref_den == 5'h1F)
      else $error("range 0 tap wrong");
   AST_REF_RANGE1: assert property (
      (ref_q[ACC_REF_EN] && ref_q[ACC_REF_RNG])
         |-> ref_num == {1'b0, ref_q[3:0]} && ref_den == 5'h17)
      else $error("range 1 tap wrong");
   AST_PIN_OUT: assert property (
      ##1 cmp0_output_pin == ($past(result[0]) ^ $past(ctl_q[0][1])))
      else $error("output pin does not follow result");
   AST_OE_DRIVE: assert property (
      ##1 cmp1_shared_pin_oe_n == !$past(ctl_q[1][ACC_CTL_DRV]))
      else $error("shared pin enable does not follow drive bit");
   AST_RIS_STICKY: assert property (
      (ris_q[2] && !clr[2]) |=> ris_q[2])
      else $error("raw flag dropped without a clear");
   AST_RDATA_PULSE: assert property (
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside read cycle");
endmodule

// [hdl/acc_pkg.sv]
package acc_pkg;
   localparam int         ACC_NCH      = 3;
   localparam int         ACC_VW       = 10;  // input voltage code width
   localparam int         ACC_PW       = ACC_VW + 5;
   localparam int         ACC_AW       = 8;
   // register offsets
   localparam logic [7:0] ACC_MIS_OFS  = 8'h00;
   localparam logic [7:0] ACC_RIS_OFS  = 8'h04;
   localparam logic [7:0] ACC_INTEN_OFS = 8'h08;
   localparam logic [7:0] ACC_REF_OFS  = 8'h10;
   localparam logic [7:0] ACC_STAT_OFS = 8'h20;
   localparam logic [7:0] ACC_CTL_OFS  = 8'h24;
   localparam logic [7:0] ACC_CH_STEP  = 8'h20;
   // reference control fields
   localparam int         ACC_REF_EN   = 9;
   localparam int         ACC_REF_RNG  = 8;
   localparam int         ACC_REF_TAP  = 0;   // bits 3:0
   localparam logic [4:0] ACC_TAP_OFS8 = 5'h08;
   localparam logic [4:0] ACC_DEN_R0   = 5'h1F;  // 31-unit ladder
   localparam logic [4:0] ACC_DEN_R1   = 5'h17;  // 23-unit ladder
   // channel control fields
   localparam int         ACC_CTL_INV  = 1;
   localparam int         ACC_CTL_SNS  = 2;   // bits 3:2
   localparam int         ACC_CTL_SRC  = 9;   // bits 10:9
   localparam int         ACC_CTL_DRV  = 11;
   localparam logic [11:0] ACC_CTL_MASK = 12'hE0E;
   localparam int         ACC_STAT_RES = 1;
   // reset values
   localparam logic [31:0] ACC_RST_WORD = 32'h0000_0000;
   localparam logic [2:0]  ACC_RST_FLAG = 3'h0;

   typedef enum logic [1:0] {
      ACC_SRC_OWN,
      ACC_SRC_C0P,
      ACC_SRC_REF,
      ACC_SRC_RSV
   } acc_src_t;

   typedef enum logic [1:0] {
      ACC_SNS_LEVEL,
      ACC_SNS_FALL,
      ACC_SNS_RISE,
      ACC_SNS_BOTH
   } acc_sns_t;

   // neg below num/den of full scale
   function automatic logic acc_below_ref(
      input logic [ACC_VW-1:0] neg,
      input logic [4:0]        num,
      input logic [4:0]        den);
      logic [ACC_PW-1:0] lhs;
      logic [ACC_PW-1:0] rhs;
      lhs = ACC_PW'(neg) * ACC_PW'(den);
      rhs = ACC_PW'(num) << ACC_VW;
      return lhs < rhs;
   endfunction
endpackage

// [hdl/acc_chan.sv]
`timescale 1ns/1ps
module acc_chan
   import acc_pkg::*;
#(
   parameter int VW    = ACC_VW,
   parameter bit IS_C0 = 1'b0
) (
   input  wire logic          core_clk,
   input  wire logic          reset_n,
   input  wire logic [VW-1:0] neg_pin,
   input  wire logic [VW-1:0] pos_pin,
   input  wire logic [VW-1:0] c0_pos,
   input  wire logic [1:0]    src,
   input  wire logic [1:0]    sense,
   input  wire logic [4:0]    ref_num,
   input  wire logic [4:0]    ref_den,
   output logic [VW-1:0]      pos_sync,
   output logic               result_q,
   output logic               event_q
);
   logic [VW-1:0] neg_m_q, neg_s_q, pos_m_q, pos_s_q;
   logic          result_d, prev_q, event_d;

   // two-stage synchronisers on the pin codes
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         neg_m_q <= '0;
         neg_s_q <= '0;
         pos_m_q <= '0;
         pos_s_q <= '0;
         result_q <= 1'b0;
         prev_q   <= 1'b0;
         event_q  <= 1'b0;
      end else begin
         neg_m_q <= neg_pin;
         neg_s_q <= neg_m_q;
         pos_m_q <= pos_pin;
         pos_s_q <= pos_m_q;
         result_q <= result_d;
         prev_q   <= result_q;
         event_q  <= event_d;
      end
   end

   assign pos_sync = pos_s_q;

   // positive source select and compare
   always_comb begin
      result_d = 1'b0;
      case (acc_src_t'(src))
         ACC_SRC_OWN: result_d = neg_s_q < pos_s_q;
         ACC_SRC_C0P: result_d = IS_C0 ? (neg_s_q < pos_s_q)
                                       : (neg_s_q < c0_pos);
         ACC_SRC_REF: result_d = acc_below_ref(neg_s_q, ref_num, ref_den);
         default:     result_d = 1'b0;
      endcase
   end

   // interrupt event by sense mode
   always_comb begin
      event_d = 1'b0;
      case (acc_sns_t'(sense))
         ACC_SNS_LEVEL: event_d = result_q;
         ACC_SNS_FALL:  event_d = prev_q & ~result_q;
         ACC_SNS_RISE:  event_d = ~prev_q & result_q;
         default:       event_d = prev_q ^ result_q;
      endcase
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   AST_OWN_COMPARE: assert property (
      $past(src) == 2'h0 |-> result_q == ($past(neg_s_q) < $past(pos_s_q)))
      else $error("own-pin compare result wrong");
   AST_C0P_COMPARE: assert property (
      (!IS_C0 && $past(src) == 2'h1)
         |-> result_q == ($past(neg_s_q) < $past(c0_pos)))
      else $error("channel 0 positive source compare wrong");
   AST_RSV_ZERO: assert property (
      $past(src) == 2'h3 |-> !result_q)
      else $error("reserved source gave a result");
   AST_RISE_EVENT: assert property (
      (sense == 2'h2 && $rose(result_q)) |=> event_q)
      else $error("rising edge event missed");
   AST_FALL_EVENT: assert property (
      (sense == 2'h1 && $fell(result_q)) |=> event_q)
      else $error("falling edge event missed");
endmodule

// [dv/test_acc_top.sv]
`timescale 1ns/1ps
module test_acc_top;
   import acc_pkg::*;
   logic              core_clk;
   logic              reset_n;
   logic [ACC_AW-1:0] reg_addr;
   logic [31:0]       reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [31:0]       reg_rdata;
   logic              irq;
   logic [ACC_VW-1:0] n0, p0, n1, n2, s1, s2;
   logic              out0, out1, oe1_n, out2, oe2_n;
   int                n_fail;
   int                checked;

   acc_top dut (
      .core_clk            (core_clk),
      .reset_n             (reset_n),
      .reg_addr            (reg_addr),
      .reg_wdata           (reg_wdata),
      .reg_wr              (reg_wr),
      .reg_rd              (reg_rd),
      .reg_rdata           (reg_rdata),
      .irq                 (irq),
      .cmp0_negative_input (n0),
      .cmp0_positive_input (p0),
      .cmp1_negative_input (n1),
      .cmp2_negative_input (n2),
      .cmp1_shared_pin_in  (s1),
      .cmp2_shared_pin_in  (s2),
      .cmp0_output_pin     (out0),
      .cmp1_shared_pin_out (out1),
      .cmp1_shared_pin_oe_n(oe1_n),
      .cmp2_shared_pin_out (out2),
      .cmp2_shared_pin_oe_n(oe2_n)
   );

   // clock, 100 ns period
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   // read strobe, data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // drive analog codes, then let sync and compare settle
   task automatic setin(input logic [9:0] a, b, c, d, e, f);
      @(posedge core_clk);
      n0 <= a; p0 <= b; n1 <= c; n2 <= d; s1 <= e; s2 <= f;
      repeat (6) @(posedge core_clk);
   endtask

   function automatic logic [7:0] ctl(input int ch);
      return ACC_CTL_OFS + 8'(ch) * ACC_CH_STEP;
   endfunction

   function automatic logic [7:0] stat(input int ch);
      return ACC_STAT_OFS + 8'(ch) * ACC_CH_STEP;
   endfunction

   // reset values, access kinds, unmapped place
   task automatic t_regs;
      logic [31:0] d;
      logic [7:0]  map [10] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20,
                                 8'h24, 8'h40, 8'h44, 8'h60, 8'h64};
      foreach (map[i]) begin
         rd(map[i], d);
         check(d, 32'h0000_0000);
      end
      check({oe2_n, oe1_n, out2, out1, out0}, 32'h0000_0018);
      wr(8'h0C, 32'hFFFF_FFFF);
      rd(8'h0C, d);
      check(d, 32'h0000_0000);
      wr(8'h04, 32'hFFFF_FFFF);
      rd(8'h04, d);
      check(d, 32'h0000_0000);
      wr(ACC_INTEN_OFS, 32'hFFFF_FFFF);
      rd(ACC_INTEN_OFS, d);
      check(d, 32'h0000_0007);
      wr(ACC_INTEN_OFS, 32'h0000_0000);
      wr(ctl(1), 32'hFFFF_FFFF);
      rd(ctl(1), d);
      check(d, 32'(ACC_CTL_MASK));
      wr(ctl(1), 32'h0000_0000);
   endtask

   // channel 0 sources against own pin and reference
   task automatic t_src0;
      logic [31:0] d;
      logic        e [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      wr(ACC_REF_OFS, 32'h0000_0300);
      setin(10'd100, 10'd200, 10'd0, 10'd0, 10'd0, 10'd0);
      for (int s = 0; s < 4; s++) begin
         wr(ctl(0), 32'(s) << ACC_CTL_SRC);
         repeat (5) @(posedge core_clk);
         rd(stat(0), d);
         check(d, 32'(e[s]) << ACC_STAT_RES);
      end
      setin(10'd300, 10'd200, 10'd0, 10'd0, 10'd0, 10'd0);
      wr(ctl(0), 32'h0000_0000);
      repeat (5) @(posedge core_clk);
      rd(stat(0), d);
      check(d, 32'h0000_0000);
   endtask

   // channels 1 and 2: own pin, channel 0 positive, reference, reserved
   task automatic t_src12;
      logic [31:0] d;
      logic        e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      wr(ACC_REF_OFS, 32'h0000_030F);
      setin(10'd0, 10'd200, 10'd100, 10'd100, 10'd50, 10'd50);
      for (int ch = 1; ch < 3; ch++)
         for (int s = 0; s < 4; s++) begin
            wr(ctl(ch), 32'(s) << ACC_CTL_SRC);
            repeat (5) @(posedge core_clk);
            rd(stat(ch), d);
            check(d, 32'(e[s]) << ACC_STAT_RES);
         end
      // drive pin 1, positive input from the reference, inverted
      wr(ctl(1), 32'h0000_0C02);
      wr(ctl(2), 32'h0000_0000);
      repeat (3) @(posedge core_clk);
      #1 check({oe2_n, oe1_n, out1}, 32'h0000_0004);
   endtask

   // reference ladder, boundary codes on each side of the tap
   task automatic t_ref;
      logic [31:0] d;
      int          c [8][4] = '{'{0, 1, 15, 0}, '{1, 0, 4, 396},
                                 '{1, 0, 4, 397}, '{1, 1, 7, 311},
                                 '{1, 1, 7, 312}, '{1, 0, 15, 759},
                                 '{1, 0, 15, 760}, '{1, 1, 0, 0}};
      int          num, den;
      logic        e;
      wr(ctl(0), 32'h0000_0400);
      foreach (c[i]) begin
         num = c[i][1] ? c[i][2] : c[i][2] + 8;
         den = c[i][1] ? 23 : 31;
         e   = c[i][0] != 0 && c[i][3] * den < num * 1024;
         wr(ACC_REF_OFS, 32'(c[i][0] * 512 + c[i][1] * 256 + c[i][2]));
         setin(10'(c[i][3]), 10'd0, 10'd0, 10'd0, 10'd0, 10'd0);
         rd(stat(0), d);
         check(d, 32'(e) << ACC_STAT_RES);
      end
   endtask

   // raw, masked, enable, irq line, write-one clear, output invert
   task automatic t_irq;
      logic [31:0] d;
      wr(ACC_MIS_OFS, 32'h0000_0007);
      wr(ctl(0), 32'h0000_0002);
      setin(10'd100, 10'd200, 10'd0, 10'd0, 10'd0, 10'd0);
      #1 check({irq, out0}, 32'h0000_0000);
      rd(ACC_RIS_OFS, d);
      check(d, 32'h0000_0001);
      rd(ACC_MIS_OFS, d);
      check(d, 32'h0000_0000);
      wr(ACC_INTEN_OFS, 32'h0000_0001);
      repeat (3) @(posedge core_clk);
      #1 check(irq, 1'b1);
      rd(ACC_MIS_OFS, d);
      check(d, 32'h0000_0001);
      setin(10'd300, 10'd200, 10'd0, 10'd0, 10'd0, 10'd0);
      wr(ACC_MIS_OFS, 32'h0000_0001);
      repeat (3) @(posedge core_clk);
      #1 check(irq, 1'b0);
      rd(ACC_RIS_OFS, d);
      check(d, 32'h0000_0000);
      // rising edge on channel 2 through the reference
      wr(ACC_REF_OFS, 32'h0000_030F);
      setin(10'd0, 10'd0, 10'd0, 10'd900, 10'd0, 10'd0);
      wr(ctl(2), 32'h0000_0408);
      wr(ACC_INTEN_OFS, 32'h0000_0004);
      repeat (3) @(posedge core_clk);
      #1 check(irq, 1'b0);
      setin(10'd0, 10'd0, 10'd0, 10'd10, 10'd0, 10'd0);
      #1 check(irq, 1'b1);
      rd(ACC_MIS_OFS, d);
      check(d, 32'h0000_0004);
      wr(ACC_MIS_OFS, 32'h0000_0004);
      repeat (3) @(posedge core_clk);
      #1 check(irq, 1'b0);
      // falling edge on channel 2 through the reference
      wr(ctl(2), 32'h0000_0404);
      setin(10'd0, 10'd0, 10'd0, 10'd900, 10'd0, 10'd0);
      #1 check(irq, 1'b1);
      rd(ACC_MIS_OFS, d);
      check(d, 32'h0000_0004);
   endtask

   // watchdog on a hang
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      summarize();
   end

   // main sequence
   initial begin
      n_fail = 0;
      checked = 0;
      reset_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      {n0, p0, n1, n2, s1, s2} = '0;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      t_regs();
      t_src0();
      t_src12();
      t_ref();
      t_irq();
      summarize();
   end
endmodule
